/* hw/dma_pkg.sv */
// shared constants and types of the four-channel dma controller
package dma_pkg;

  localparam int NUM_CH = 4;

  // host port offsets on the four address lines
  localparam logic [3:0] OFS_STATUS       = 4'h8;
  localparam logic [3:0] OFS_COMMAND      = 4'h8;
  localparam logic [3:0] OFS_SINGLE_MASK  = 4'ha;
  localparam logic [3:0] OFS_MODE         = 4'hb;
  localparam logic [3:0] OFS_CLEAR_PTR    = 4'hc;
  localparam logic [3:0] OFS_MASTER_CLEAR = 4'hd;
  localparam logic [3:0] OFS_CLEAR_MASK   = 4'he;
  localparam logic [3:0] OFS_ALL_MASK     = 4'hf;

  // address line roles for channel register accesses
  localparam int ADDR_BANK_BIT = 3;
  localparam int ADDR_CH_MSB   = 2;
  localparam int ADDR_CH_LSB   = 1;
  localparam int ADDR_SEL_BIT  = 0;

  // command register fields
  localparam int CMD_DISABLE_BIT    = 2;
  localparam int CMD_COMPRESSED_BIT = 3;
  localparam int CMD_EXT_WRITE_BIT  = 5;
  localparam int CMD_REQ_LOW_BIT    = 6;
  localparam int CMD_GRANT_HIGH_BIT = 7;

  // single mask write fields
  localparam int SMASK_SET_BIT = 2;

  // reset values
  localparam logic [7:0]  CMD_RESET   = 8'h00;
  localparam logic [3:0]  MASK_RESET  = 4'hf;
  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // transfer types held in the mode field
  localparam logic [1:0] XFER_VERIFY = 2'b00;
  localparam logic [1:0] XFER_WRITE  = 2'b01;
  localparam logic [1:0] XFER_READ   = 2'b10;

  // count and address boundaries
  localparam logic [15:0] COUNT_LAST   = 16'h0000;
  localparam logic [15:0] WORD_ONE     = 16'h0001;
  localparam logic [7:0]  ADDR_LOW_MAX = 8'hff;
  localparam logic [7:0]  ADDR_LOW_MIN = 8'h00;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] count;
  } chan_state_t;

  typedef struct packed {
    logic [1:0] op_sel;
    logic       dec;
    logic       autoinit;
    logic [1:0] xfer;
  } mode_t;

  typedef struct packed {
    logic       we;
    logic       sel_count;
    logic       hi;
    logic [7:0] data;
  } host_wr_t;

  localparam mode_t MODE_RESET = '0;

endpackage

/* hw/dma_chan_regs.sv */
// base and current address and count registers of one channel
`timescale 1ns/10ps
module dma_chan_regs
  import dma_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  host_wr_t   host_wr,
  input  wire logic  step,
  input  wire logic  step_dec,
  input  wire logic  reload,
  output chan_state_t cur
);

  chan_state_t base_reg;
  chan_state_t base_next;
  chan_state_t cur_reg;
  chan_state_t cur_next;

  always_comb begin
    base_next = base_reg;
    cur_next  = cur_reg;
    if (host_wr.we) begin
      if (host_wr.sel_count && host_wr.hi) begin
        base_next.count[15:8] = host_wr.data;
        cur_next.count[15:8]  = host_wr.data;
      end else if (host_wr.sel_count) begin
        base_next.count[7:0] = host_wr.data;
        cur_next.count[7:0]  = host_wr.data;
      end else if (host_wr.hi) begin
        base_next.addr[15:8] = host_wr.data;
        cur_next.addr[15:8]  = host_wr.data;
      end else begin
        base_next.addr[7:0] = host_wr.data;
        cur_next.addr[7:0]  = host_wr.data;
      end
    end else if (step && reload) begin
      cur_next = base_reg;
    end else if (step) begin
      cur_next.addr  = step_dec ? cur_reg.addr - WORD_ONE : cur_reg.addr + WORD_ONE;
      cur_next.count = cur_reg.count - WORD_ONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_reg <= '0;
      cur_reg  <= '0;
    end else begin
      base_reg <= base_next;
      cur_reg  <= cur_next;
    end
  end

  assign cur = cur_reg;

endmodule // dma_chan_regs

/* hw/dma_req_arbiter.sv */
// request polarity, masking and fixed priority pick
`timescale 1ns/10ps
module dma_req_arbiter
  import dma_pkg::*;
(
  input  wire logic [3:0] raw_req,
  input  wire logic       req_low,
  input  wire logic [3:0] mask,
  input  wire logic       ctrl_off,
  output logic      [3:0] active,
  output logic      [3:0] pending,
  output logic            any,
  output logic      [1:0] pick
);

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_req
      assign active[i]  = raw_req[i] ^ req_low;
      assign pending[i] = active[i] & ~mask[i] & ~ctrl_off;
    end
  endgenerate

  assign any = |pending;

  always_comb begin
    pick = 2'h0;
    if (pending[0]) pick = 2'h0;
    else if (pending[1]) pick = 2'h1;
    else if (pending[2]) pick = 2'h2;
    else if (pending[3]) pick = 2'h3;
  end

endmodule // dma_req_arbiter

/* hw/dma_controller.sv */
// four-channel dma controller: host programming port and bus handoff
`timescale 1ns/10ps
// Behaviour
// - low address lines pick channel and register
// - byte pointer selects low or high byte
// - writes load base and current; reads current
// - accept programming whenever hold grant inactive
// - enabled unmasked request served despite partial rewrite
// - hold request while any valid request pending
// - on grant drive address, data, strobes
// - first transfer: high address via data bus
// - refresh high latch only on carry/borrow
// - selectable polarity of requests and grants
// - write one/two clocks, read two/one clocks
// - write strobe ends no later than read
// - pointer toggles per channel register access, cleared by command
// - transfers equal count plus one, wrap signals end
// - base copies never readable by host
module dma_controller
  import dma_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       CS_N,
  input  wire logic [3:0] ADDR_LO_IN,
  output logic      [7:0] ADDR_LO_OUT,
  output logic            ADDR_LO_OE,
  input  wire logic [7:0] DB_IN,
  output logic      [7:0] DB_OUT,
  output logic            DB_OE,
  input  wire logic       IO_READ_STROBE_N_IN,
  output logic            IO_READ_STROBE_N_OUT,
  output logic            IO_READ_STROBE_OE,
  input  wire logic       IO_WRITE_STROBE_N_IN,
  output logic            IO_WRITE_STROBE_N_OUT,
  output logic            IO_WRITE_STROBE_OE,
  output logic            MEMORY_READ_STROBE_N,
  output logic            MEMORY_WRITE_STROBE_N,
  output logic            MEMORY_STROBE_OE,
  output logic            HOLD_REQUEST_OUT,
  input  wire logic       HOLD_GRANT_IN,
  input  wire logic [3:0] CHANNEL_REQUEST_IN,
  output logic      [3:0] CHANNEL_GRANT_OUT,
  output logic            HIGH_ADDRESS_STROBE,
  output logic            ADDRESS_DRIVE_ENABLE,
  output logic            END_OF_PROCESS
);

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_GRANT, ST_S1, ST_S2, ST_S3, ST_S4} xfer_state_t;

  // host strobe edge detection
  logic        ior_prev_reg;
  logic        ior_prev_next;
  logic        iow_prev_reg;
  logic        iow_prev_next;
  logic        host_ok;
  logic        rd_start;
  logic        wr_start;
  logic        chan_access;
  logic [1:0]  host_ch;
  logic        host_sel_count;

  // programming state
  logic        ptr_reg;
  logic        ptr_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  logic [3:0]  mask_reg;
  logic [3:0]  mask_next;
  logic [3:0]  flags_reg;
  logic [3:0]  flags_next;
  mode_t       mode_reg [NUM_CH];
  mode_t       mode_next [NUM_CH];
  logic [7:0]  rd_byte;
  logic        master_clear;

  // transfer state
  xfer_state_t state_reg;
  xfer_state_t state_next;
  logic [1:0]  act_ch_reg;
  logic [1:0]  act_ch_next;
  logic [7:0]  db_out_reg;
  logic [7:0]  db_out_next;
  logic        eop_reg;
  logic        eop_next;

  // channel and arbiter wiring
  chan_state_t cur [NUM_CH];
  host_wr_t    host_wr [NUM_CH];
  logic [3:0]  step_vec;
  logic [3:0]  active;
  logic [3:0]  pending;
  logic        any_pending;
  logic [1:0]  pick;
  chan_state_t act_cur;
  mode_t       act_mode;
  logic [15:0] addr_step;
  logic        carry;
  logic        tc;
  logic        cont;
  logic        owning;
  logic        compressed;
  logic        rd_phase;
  logic        wr_phase;
  logic [3:0]  grant_vec;

  assign host_ok        = ~CS_N & ~HOLD_GRANT_IN;
  assign rd_start       = host_ok & ~IO_READ_STROBE_N_IN & ior_prev_reg;
  assign wr_start       = host_ok & ~IO_WRITE_STROBE_N_IN & iow_prev_reg;
  assign chan_access    = ~ADDR_LO_IN[ADDR_BANK_BIT];
  assign host_ch        = ADDR_LO_IN[ADDR_CH_MSB:ADDR_CH_LSB];
  assign host_sel_count = ADDR_LO_IN[ADDR_SEL_BIT];
  assign master_clear   = wr_start & (ADDR_LO_IN == OFS_MASTER_CLEAR);
  assign ior_prev_next  = IO_READ_STROBE_N_IN;
  assign iow_prev_next  = IO_WRITE_STROBE_N_IN;

  assign act_cur    = cur[act_ch_reg];
  assign act_mode   = mode_reg[act_ch_reg];
  assign addr_step  = act_mode.dec ? act_cur.addr - WORD_ONE : act_cur.addr + WORD_ONE;
  assign carry      = act_mode.dec ? (act_cur.addr[7:0] == ADDR_LOW_MIN) : (act_cur.addr[7:0] == ADDR_LOW_MAX);
  assign tc         = (state_reg == ST_S4) & (act_cur.count == COUNT_LAST);
  assign compressed = cmd_reg[CMD_COMPRESSED_BIT];
  assign owning     = (state_reg == ST_S1) | (state_reg == ST_S2) | (state_reg == ST_S3) | (state_reg == ST_S4);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      assign host_wr[g].we        = wr_start & chan_access & (host_ch == 2'(g));
      assign host_wr[g].sel_count = host_sel_count;
      assign host_wr[g].hi        = ptr_reg;
      assign host_wr[g].data      = DB_IN;
      assign step_vec[g]          = (state_reg == ST_S4) & (act_ch_reg == 2'(g));
      assign grant_vec[g]         = owning & (act_ch_reg == 2'(g));

      dma_chan_regs u_chan (
        .clk      (CLK_SYS),
        .rst      (RST),
        .host_wr  (host_wr[g]),
        .step     (step_vec[g]),
        .step_dec (mode_reg[g].dec),
        .reload   (mode_reg[g].autoinit & (cur[g].count == COUNT_LAST)),
        .cur      (cur[g])
      );
    end
  endgenerate

  dma_req_arbiter u_arb (
    .raw_req  (CHANNEL_REQUEST_IN),
    .req_low  (cmd_reg[CMD_REQ_LOW_BIT]),
    .mask     (mask_reg),
    .ctrl_off (cmd_reg[CMD_DISABLE_BIT]),
    .active   (active),
    .pending  (pending),
    .any      (any_pending),
    .pick     (pick)
  );

  // host read data: current copies only, status, otherwise zero
  always_comb begin
    rd_byte = BYTE_ZERO;
    if (chan_access && host_sel_count) begin
      rd_byte = ptr_reg ? cur[host_ch].count[15:8] : cur[host_ch].count[7:0];
    end else if (chan_access) begin
      rd_byte = ptr_reg ? cur[host_ch].addr[15:8] : cur[host_ch].addr[7:0];
    end else if (ADDR_LO_IN == OFS_STATUS) begin
      rd_byte = {active, flags_reg};
    end
  end

  // programming registers
  always_comb begin
    ptr_next   = ptr_reg;
    cmd_next   = cmd_reg;
    mask_next  = mask_reg;
    flags_next = flags_reg;
    for (int i = 0; i < NUM_CH; i++) begin
      mode_next[i] = mode_reg[i];
    end
    if ((rd_start || wr_start) && chan_access) begin
      ptr_next = ~ptr_reg;
    end
    if (rd_start && (ADDR_LO_IN == OFS_STATUS)) begin
      flags_next = FLAGS_RESET;
    end
    if (wr_start) begin
      unique case (ADDR_LO_IN)
        OFS_COMMAND:      cmd_next = DB_IN;
        OFS_SINGLE_MASK:  mask_next[DB_IN[1:0]] = DB_IN[SMASK_SET_BIT];
        OFS_MODE:         mode_next[DB_IN[1:0]] = DB_IN[7:2];
        OFS_CLEAR_PTR:    ptr_next = 1'b0;
        OFS_CLEAR_MASK:   mask_next = 4'h0;
        OFS_ALL_MASK:     mask_next = DB_IN[3:0];
        OFS_MASTER_CLEAR: begin
          ptr_next   = 1'b0;
          cmd_next   = CMD_RESET;
          mask_next  = MASK_RESET;
          flags_next = FLAGS_RESET;
        end
        default: ;
      endcase
    end
    if (tc) begin
      flags_next[act_ch_reg] = 1'b1;
      if (!act_mode.autoinit) begin
        mask_next[act_ch_reg] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ior_prev_reg <= 1'b1;
      iow_prev_reg <= 1'b1;
      ptr_reg      <= 1'b0;
      cmd_reg      <= CMD_RESET;
      mask_reg     <= MASK_RESET;
      flags_reg    <= FLAGS_RESET;
      for (int i = 0; i < NUM_CH; i++) begin
        mode_reg[i] <= MODE_RESET;
      end
    end else begin
      ior_prev_reg <= ior_prev_next;
      iow_prev_reg <= iow_prev_next;
      ptr_reg      <= ptr_next;
      cmd_reg      <= cmd_next;
      mask_reg     <= mask_next;
      flags_reg    <= flags_next;
      for (int i = 0; i < NUM_CH; i++) begin
        mode_reg[i] <= mode_next[i];
      end
    end
  end

  // continue a demand burst while the same request stays valid
  assign cont = ~tc & pending[act_ch_reg] & HOLD_GRANT_IN;

  // transfer sequencer
  always_comb begin
    state_next  = state_reg;
    act_ch_next = act_ch_reg;
    db_out_next = db_out_reg;
    eop_next    = 1'b0;
    if (rd_start) begin
      db_out_next = rd_byte;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (any_pending) begin
          state_next  = ST_WAIT_GRANT;
          act_ch_next = pick;
        end
      end
      ST_WAIT_GRANT: begin
        if (!any_pending) begin
          state_next = ST_IDLE;
        end else if (HOLD_GRANT_IN) begin
          state_next  = ST_S1;
          act_ch_next = pick;
          db_out_next = cur[pick].addr[15:8];
        end else begin
          act_ch_next = pick;
        end
      end
      ST_S1: begin
        state_next = compressed ? ST_S3 : ST_S2;
      end
      ST_S2: begin
        state_next = ST_S3;
      end
      ST_S3: begin
        state_next = ST_S4;
      end
      ST_S4: begin
        eop_next = tc;
        if (cont && carry) begin
          state_next  = ST_S1;
          db_out_next = addr_step[15:8];
        end else if (cont) begin
          state_next = compressed ? ST_S3 : ST_S2;
        end else begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (master_clear) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg  <= ST_IDLE;
      act_ch_reg <= 2'h0;
      db_out_reg <= BYTE_ZERO;
      eop_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      act_ch_reg <= act_ch_next;
      db_out_reg <= db_out_next;
      eop_reg    <= eop_next;
    end
  end

  // strobe phases: read S2..S3 normal or S3 compressed, write S3 or S2..S3 extended
  assign rd_phase = ((state_reg == ST_S2) & ~compressed) | (state_reg == ST_S3);
  assign wr_phase = ((state_reg == ST_S2) & cmd_reg[CMD_EXT_WRITE_BIT]) | (state_reg == ST_S3);

  assign HOLD_REQUEST_OUT      = any_pending | (state_reg == ST_WAIT_GRANT) | owning;
  assign ADDRESS_DRIVE_ENABLE  = owning;
  assign HIGH_ADDRESS_STROBE   = (state_reg == ST_S1);
  assign ADDR_LO_OUT           = act_cur.addr[7:0];
  assign ADDR_LO_OE            = owning;
  assign DB_OUT                = db_out_reg;
  assign DB_OE                 = (host_ok & ~IO_READ_STROBE_N_IN & ~ior_prev_reg) | (state_reg == ST_S1);
  assign IO_READ_STROBE_N_OUT  = ~(rd_phase & (act_mode.xfer == XFER_WRITE));
  assign IO_WRITE_STROBE_N_OUT = ~(wr_phase & (act_mode.xfer == XFER_READ));
  assign MEMORY_READ_STROBE_N  = ~(rd_phase & (act_mode.xfer == XFER_READ));
  assign MEMORY_WRITE_STROBE_N = ~(wr_phase & (act_mode.xfer == XFER_WRITE));
  assign IO_READ_STROBE_OE     = owning;
  assign IO_WRITE_STROBE_OE    = owning;
  assign MEMORY_STROBE_OE      = owning;
  assign CHANNEL_GRANT_OUT     = cmd_reg[CMD_GRANT_HIGH_BIT] ? grant_vec : ~grant_vec;
  assign END_OF_PROCESS        = eop_reg;

endmodule // dma_controller

/* verification/dma_monitor.sv */
// pin-level assertions of the dma controller
`timescale 1ns/10ps
module dma_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       IO_READ_STROBE_N_IN,
  input wire logic [7:0] ADDR_LO_OUT,
  input wire logic       ADDR_LO_OE,
  input wire logic       DB_OE,
  input wire logic       IO_READ_STROBE_N_OUT,
  input wire logic       IO_READ_STROBE_OE,
  input wire logic       IO_WRITE_STROBE_OE,
  input wire logic       MEMORY_READ_STROBE_N,
  input wire logic       MEMORY_WRITE_STROBE_N,
  input wire logic       MEMORY_STROBE_OE,
  input wire logic       HOLD_REQUEST_OUT,
  input wire logic       HOLD_GRANT_IN,
  input wire logic       HIGH_ADDRESS_STROBE,
  input wire logic       ADDRESS_DRIVE_ENABLE,
  input wire logic       END_OF_PROCESS
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  grant_then_drive_a: assert property ($rose(ADDRESS_DRIVE_ENABLE) |-> $past(HOLD_GRANT_IN) && HIGH_ADDRESS_STROBE)
    else $error("bus taken without grant or without high address cycle");
  high_addr_out_a: assert property (HIGH_ADDRESS_STROBE |-> DB_OE && ADDR_LO_OE && ADDRESS_DRIVE_ENABLE)
    else $error("high address cycle without both buses driven");
  own_outputs_a: assert property (ADDRESS_DRIVE_ENABLE |-> HOLD_REQUEST_OUT && HOLD_GRANT_IN && MEMORY_STROBE_OE
                                  && IO_READ_STROBE_OE && IO_WRITE_STROBE_OE)
    else $error("bus owned without request, grant or strobe drive");
  idle_strobes_a: assert property (!ADDRESS_DRIVE_ENABLE |-> MEMORY_READ_STROBE_N && MEMORY_WRITE_STROBE_N)
    else $error("memory strobe active while not owning");
  latch_on_wrap_a: assert property (HIGH_ADDRESS_STROBE && $past(ADDRESS_DRIVE_ENABLE)
                                    |-> ADDR_LO_OUT == 8'h00 || ADDR_LO_OUT == 8'hff)
    else $error("high address refreshed without carry or borrow");
  write_width_a: assert property ($fell(MEMORY_WRITE_STROBE_N) |-> ##[1:2] MEMORY_WRITE_STROBE_N)
    else $error("memory write strobe too long");
  read_width_a: assert property ($fell(IO_READ_STROBE_N_OUT) |-> ##[1:2] IO_READ_STROBE_N_OUT)
    else $error("io read strobe too long");
  write_ends_first_a: assert property ($rose(IO_READ_STROBE_N_OUT) |-> MEMORY_WRITE_STROBE_N)
    else $error("write strobe outlasts read strobe");
  end_pulse_a: assert property (END_OF_PROCESS |-> $past(ADDRESS_DRIVE_ENABLE) ##1 !END_OF_PROCESS)
    else $error("end of process pulse misplaced");
  host_read_a: assert property (DB_OE && !ADDRESS_DRIVE_ENABLE |-> !$past(CS_N) && !$past(IO_READ_STROBE_N_IN))
    else $error("data bus driven without selected read");
endmodule // dma_monitor

/* verification/hold_grant_model.sv */
// bus owner model: grants the hold after a set delay
`timescale 1ns/10ps
module hold_grant_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold_req,
  input  wire logic       host_busy,
  input  wire logic [7:0] delay,
  output logic            hold_grant
);
  logic [7:0] wait_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg   <= 8'h00;
      hold_grant <= 1'b0;
    end else begin
      wait_reg   <= (hold_req && !hold_grant) ? wait_reg + 8'h01 : 8'h00;
      hold_grant <= hold_req && (hold_grant || (wait_reg >= delay && !host_busy));
    end
  end
endmodule // hold_grant_model

/* verification/tb_top.sv */
// self-checking bench of the dma controller
`timescale 1ns/10ps
module tb_top
  import dma_pkg::*;
;
  logic        clk, rst, cs_n, rd_n, wr_n, grant, hold_request_out, db_oe, eop, oe_q;
  logic [3:0]  addr, req, channel_grant_out;
  logic [7:0]  db_in, db_out, dly, hi;
  logic [15:0] va [4];
  logic [7:0]  exp_q [$];
  int          num_errors, n_compared, i;

  always #25 clk = ~clk;

  dma_controller i_dut (
    .CLK_SYS(clk), .RST(rst), .CS_N(cs_n), .ADDR_LO_IN(addr), .ADDR_LO_OUT(), .ADDR_LO_OE(),
    .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .IO_READ_STROBE_N_IN(rd_n), .IO_READ_STROBE_N_OUT(),
    .IO_READ_STROBE_OE(), .IO_WRITE_STROBE_N_IN(wr_n), .IO_WRITE_STROBE_N_OUT(), .IO_WRITE_STROBE_OE(),
    .MEMORY_READ_STROBE_N(), .MEMORY_WRITE_STROBE_N(), .MEMORY_STROBE_OE(), .HOLD_REQUEST_OUT(hold_request_out),
    .HOLD_GRANT_IN(grant), .CHANNEL_REQUEST_IN(req), .CHANNEL_GRANT_OUT(channel_grant_out), .HIGH_ADDRESS_STROBE(),
    .ADDRESS_DRIVE_ENABLE(), .END_OF_PROCESS(eop));

  hold_grant_model i_host (.clk(clk), .rst(rst), .hold_req(hold_request_out), .host_busy(!cs_n), .delay(dly), .hold_grant(grant));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic wr(input logic c, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_n  <= c;
    addr  <= a;
    db_in <= d;
    wr_n  <= 1'b0;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    cs_n <= 1'b0;
    addr <= a;
    rd_n <= 1'b0;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(1'b0, a, d[7:0]);
    wr(1'b0, a, d[15:8]);
  endtask

  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a, e[15:8]);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // every byte the controller puts on the data bus is checked against the oldest note
  always @(negedge clk) begin
    if (db_oe && !oe_q)
      check("data bus", {8'h00, db_out}, exp_q.size() > 0 ? {8'h00, exp_q.pop_front()} : 16'hxxxx);
    oe_q <= db_oe;
  end

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    db_in = 8'h00;
    req = 4'h0;
    dly = 8'h28;
    oe_q = 1'b0;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(34816));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("hold request", {15'h0000, hold_request_out}, 16'h0000);
    check("grants idle", {12'h000, channel_grant_out}, 16'h000f);
    $display("test reset done");
    wr(1'b0, OFS_CLEAR_PTR, 8'h00);
    for (i = 0; i < 4; i++) begin
      va[i] = 16'($urandom());
      wr(1'b0, OFS_MODE, {6'h00, i[1:0]});
      wr16({1'b0, i[1:0], 1'b0}, va[i]);
      wr16({1'b0, i[1:0], 1'b1}, ~va[i]);
    end
    for (i = 0; i < 4; i++) begin
      rd16({1'b0, i[1:0], 1'b0}, va[i]);
      rd16({1'b0, i[1:0], 1'b1}, ~va[i]);
    end
    $display("test registers done");
    wr(1'b1, 4'h0, 8'h5a);
    rd16(4'h0, va[0]);
    $display("test deselect done");
    wr(1'b0, 4'h2, 8'hfe);
    hi = va[1][15:8];
    rd(4'h2, hi);
    $display("test pointer done");
    wr(1'b0, OFS_MODE, 8'h05);
    wr(1'b0, OFS_SINGLE_MASK, 8'h01);
    exp_q.push_back(hi);
    exp_q.push_back(hi + 8'h01);
    req <= 4'h2;
    repeat (2) @(negedge clk);
    check("hold request", {15'h0000, hold_request_out}, 16'h0001);
    wr16(4'h3, 16'h0002);
    for (i = 0; i < 300 && eop !== 1'b1; i++)
      @(negedge clk);
    check("end of process", {15'h0000, eop}, 16'h0001);
    @(posedge clk);
    req <= 4'h0;
    repeat (4) @(negedge clk);
    check("hold request", {15'h0000, hold_request_out}, 16'h0000);
    rd16(4'h2, {hi + 8'h01, 8'h01});
    rd16(4'h3, 16'hffff);
    rd(OFS_STATUS, 8'h02);
    $display("test transfer done");
    wr(1'b0, OFS_CLEAR_MASK, 8'h00);
    wr(1'b0, OFS_COMMAND, 8'hc4);
    repeat (2) @(negedge clk);
    check("hold request", {15'h0000, hold_request_out}, 16'h0000);
    check("grants idle", {12'h000, channel_grant_out}, 16'h0000);
    @(posedge clk);
    req <= 4'hf;
    wr(1'b0, OFS_COMMAND, 8'hc0);
    repeat (2) @(negedge clk);
    check("hold request", {15'h0000, hold_request_out}, 16'h0000);
    $display("test polarity done");
    results();
  end
endmodule // tb_top

bind dma_controller dma_monitor i_mon (
  .CLK_SYS, .RST, .CS_N, .IO_READ_STROBE_N_IN, .ADDR_LO_OUT, .ADDR_LO_OE, .DB_OE, .IO_READ_STROBE_N_OUT,
  .IO_READ_STROBE_OE, .IO_WRITE_STROBE_OE, .MEMORY_READ_STROBE_N, .MEMORY_WRITE_STROBE_N, .MEMORY_STROBE_OE,
  .HOLD_REQUEST_OUT, .HOLD_GRANT_IN, .HIGH_ADDRESS_STROBE, .ADDRESS_DRIVE_ENABLE, .END_OF_PROCESS);
